/* ssic_standby_ctrl.v */
// Function
// - STOP halts oscillator and all operation
// - Bit 7 of control one starts STOP
// - Resume at next instruction after warm-up
// - Memory, registers, port latches held in STOP
// - STOP entry clears prescaler and divider
// - Bit 6 selects edge or level wake
// - Level mode: high pin starts warm-up
// - Level mode: pin high skips STOP
// - Pin doubles as port and interrupt five
// - Bits 3:2 select warm-up length
// - Edge mode: rising edge ends STOP
// - Bit 4 of control two enters IDLE
// - IDLE ends on pending interrupt or interrupt zero input, master enable or not
`timescale 1ns/1ps
`default_nettype none
`include "ssic_defs.vh"

module ssic_standby_ctrl #(
  parameter [`SSIC_WARM_W-1:0] P_WARM_SHORT = 20'd65536,
  parameter [`SSIC_WARM_W-1:0] P_WARM_LONG = 20'd196608
) (
  input wire i_sys_clk,
  input wire i_rstn,
  // Avalon-MM slave
  input wire [`SSIC_ADDR_W-1:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  output reg [1:0] o_avs_response,
  // Wake pin and interrupt sources
  input wire i_wake_pin,
  input wire i_divider_input_select,
  input wire i_irq_master_enable,
  input wire i_irq_pending,
  input wire i_ext_irq_zero_input,
  // Status to the rest of the chip
  output reg o_osc_enable,
  output reg o_cpu_halt,
  output reg o_wdt_halt,
  output reg o_periph_halt,
  output reg o_hold_state,
  output reg o_divider_clear,
  output reg o_resume,
  output reg o_take_irq,
  output reg o_port_two_bit_zero,
  output reg o_ext_irq_five_input
);

  // ****************************************
  // Modes
  // ****************************************
  localparam [2:0] ST_NORMAL = 3'd0;
  localparam [2:0] ST_STOP = 3'd1;
  localparam [2:0] ST_WARM = 3'd2;
  localparam [2:0] ST_IDLE = 3'd3;
  localparam [2:0] ST_START = 3'd4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] ctrl_one;
  reg [7:0] ctrl_two;
  reg irq_five_flag;
  reg first_cyc;

  wire pin_level;
  wire pin_rise;
  wire pin_fall;
  wire warm_busy;
  wire warm_done;
  wire warm_start;

  function [7:0] merge_byte;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] mask;
    begin
      merge_byte = (old_v & ~mask) | (new_v & mask);
    end
  endfunction

  // ****************************************
  // Wake pin conditioning
  // ****************************************
  ssic_edge_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_pin(i_wake_pin),
    .o_level(pin_level),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  wire [`SSIC_ADDR_W-3:0] word_idx = i_avs_address[`SSIC_ADDR_W-1:2];
  wire hit_one = (word_idx == `SSIC_IDX_CTRL_ONE);
  wire hit_two = (word_idx == `SSIC_IDX_CTRL_TWO);
  wire hit_stat = (word_idx == `SSIC_IDX_STATUS);
  wire hit_irq = (word_idx == `SSIC_IDX_IRQ);
  wire hit_any = hit_one | hit_two | hit_stat | hit_irq;
  // Two-cycle wait, answer on third cycle
  wire acc = (i_avs_read | i_avs_write) & o_avs_waitrequest & ~first_cyc;
  // Write lands at the edge where the master sees waitrequest low
  wire wr_ok = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  wire wr_one = wr_ok & hit_one & (state == ST_NORMAL);
  wire wr_two = wr_ok & hit_two & (state == ST_NORMAL);
  wire stop_req = wr_one & i_avs_writedata[`SSIC_ONE_STOP];
  wire idle_req = wr_two & i_avs_writedata[`SSIC_TWO_IDLE];
  wire level_mode = i_avs_writedata[`SSIC_ONE_WAKE_METHOD];
  wire idle_wake = i_irq_pending | i_ext_irq_zero_input;

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      first_cyc <= 1'b1;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      o_avs_response <= 2'h0;
    end else begin
      o_avs_waitrequest <= 1'b1;
      first_cyc <= ~(i_avs_read | i_avs_write) | ~o_avs_waitrequest;
      if (acc) begin
        o_avs_waitrequest <= 1'b0;
        first_cyc <= 1'b1;
        o_avs_response <= hit_any ? 2'h0 : 2'h3;
        o_avs_readdata <= 32'h0000_0000;
        if (i_avs_read) begin
          if (hit_one) begin
            o_avs_readdata <= {24'h00_0000, ctrl_one};
          end else if (hit_two) begin
            o_avs_readdata <= {24'h00_0000, ctrl_two};
          end else if (hit_stat) begin
            o_avs_readdata <= {27'h000_0000, warm_busy, pin_level, state};
          end else if (hit_irq) begin
            o_avs_readdata <= {31'h0000_0000, irq_five_flag};
          end
        end
      end else if (!o_avs_waitrequest) begin
        first_cyc <= 1'b1;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_one <= `SSIC_ONE_RESET;
      ctrl_two <= `SSIC_TWO_RESET;
    end else begin
      if (wr_one) begin
        ctrl_one <= merge_byte(ctrl_one, i_avs_writedata[7:0], `SSIC_ONE_KEEP_MASK);
        ctrl_one[`SSIC_ONE_STOP] <= i_avs_writedata[`SSIC_ONE_STOP];
      end else if (state == ST_WARM && warm_done) begin
        ctrl_one[`SSIC_ONE_STOP] <= 1'b0;
      end
      if (wr_two) begin
        ctrl_two <= merge_byte(ctrl_two, i_avs_writedata[7:0], `SSIC_TWO_KEEP_MASK)
          | `SSIC_TWO_FIXED;
      end else if (state == ST_IDLE && idle_wake) begin
        ctrl_two[`SSIC_TWO_IDLE] <= 1'b0;
      end
    end
  end

  // Interrupt five flag; falling edge set wins over clear
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_five_flag <= 1'b0;
    end else if (pin_fall) begin
      irq_five_flag <= 1'b1;
    end else if (wr_ok & hit_irq & i_avs_writedata[0]) begin
      irq_five_flag <= 1'b0;
    end
  end

  // ****************************************
  // Mode sequencer
  // ****************************************
  always @* begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        if (stop_req) begin
          next_state = (level_mode & pin_level) ? ST_WARM : ST_START;
        end else if (idle_req) begin
          next_state = ST_IDLE;
        end
      end
      ST_START: begin
        next_state = ST_STOP;
      end
      ST_STOP: begin
        if (ctrl_one[`SSIC_ONE_WAKE_METHOD] ? pin_level : pin_rise) begin
          next_state = ST_WARM;
        end
      end
      ST_WARM: begin
        if (warm_done) begin
          next_state = ST_NORMAL;
        end
      end
      ST_IDLE: begin
        if (idle_wake) begin
          next_state = ST_NORMAL;
        end
      end
      default: begin
        next_state = ST_NORMAL;
      end
    endcase
  end

  assign warm_start = (state != ST_WARM) & (next_state == ST_WARM);

  // code 00 long, 01 short; reserved codes run the short count
  ssic_warmup #(
    .P_SHORT(P_WARM_SHORT),
    .P_LONG(P_WARM_LONG)
  ) u_warm (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_start(warm_start),
    .i_long(state == ST_NORMAL ?
      (i_avs_writedata[`SSIC_ONE_WUT_HI:`SSIC_ONE_WUT_LO] == 2'b00) :
      (ctrl_one[`SSIC_ONE_WUT_HI:`SSIC_ONE_WUT_LO] == 2'b00)),
    .i_double(i_divider_input_select),
    .o_busy(warm_busy),
    .o_done(warm_done)
  );

  // ****************************************
  // Outputs, all registered
  // ****************************************
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_NORMAL;
      o_osc_enable <= 1'b1;
      o_cpu_halt <= 1'b0;
      o_wdt_halt <= 1'b0;
      o_periph_halt <= 1'b0;
      o_hold_state <= 1'b0;
      o_divider_clear <= 1'b0;
      o_resume <= 1'b0;
      o_take_irq <= 1'b0;
      o_port_two_bit_zero <= 1'b0;
      o_ext_irq_five_input <= 1'b0;
    end else begin
      state <= next_state;
      o_osc_enable <= (next_state != ST_STOP) & (next_state != ST_START);
      o_cpu_halt <= (next_state != ST_NORMAL);
      o_wdt_halt <= (next_state != ST_NORMAL);
      o_periph_halt <= (next_state == ST_STOP) | (next_state == ST_START)
        | (next_state == ST_WARM);
      o_hold_state <= (next_state != ST_NORMAL);
      o_divider_clear <= (next_state == ST_START) | (next_state == ST_STOP)
        | ((state == ST_WARM) & warm_done);
      o_resume <= (state == ST_WARM) & warm_done;
      o_take_irq <= (state == ST_IDLE) & idle_wake & i_irq_master_enable;
      o_port_two_bit_zero <= pin_level;
      o_ext_irq_five_input <= irq_five_flag;
    end
  end

endmodule // ssic_standby_ctrl

`default_nettype wire

/* ssic_defs.vh */
`ifndef SSIC_DEFS_VH
`define SSIC_DEFS_VH

// ****************************************
// Register map (byte addresses = index * 4)
// ****************************************
`define SSIC_IDX_CTRL_ONE 8'h38
`define SSIC_IDX_CTRL_TWO 8'h39
`define SSIC_IDX_STATUS 8'h3a
`define SSIC_IDX_IRQ 8'h3b
`define SSIC_ADDR_W 10

// ****************************************
// Field positions
// ****************************************
`define SSIC_ONE_STOP 7
`define SSIC_ONE_WAKE_METHOD 6
`define SSIC_ONE_WUT_HI 3
`define SSIC_ONE_WUT_LO 2
`define SSIC_TWO_IDLE 4

// ****************************************
// Reset values and fixed bits
// ****************************************
`define SSIC_ONE_RESET 8'h00
`define SSIC_TWO_RESET 8'h80
`define SSIC_ONE_KEEP_MASK 8'h4c
`define SSIC_TWO_KEEP_MASK 8'h10
`define SSIC_TWO_FIXED 8'h80

// ****************************************
// Warm-up counts in basic clocks
// ****************************************
`define SSIC_WARM_BASE 32'd65536
`define SSIC_WARM_LONG_MUL 32'd3
`define SSIC_WARM_W 20

`endif

/* ssic_edge_sync.v */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Wake pin conditioning
// ****************************************
module ssic_edge_sync (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_pin,
  output reg o_level,
  output wire o_rise,
  output wire o_fall
);

  reg prev;

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_level <= 1'b0;
      prev <= 1'b0;
    end else begin
      o_level <= i_pin;
      prev <= o_level;
    end
  end

  assign o_rise = o_level & ~prev;
  assign o_fall = ~o_level & prev;

endmodule // ssic_edge_sync

`default_nettype wire

/* ssic_warmup.v */
`timescale 1ns/1ps
`default_nettype none
`include "ssic_defs.vh"

// ****************************************
// Warm-up down counter
// ****************************************
module ssic_warmup #(
  parameter [`SSIC_WARM_W-1:0] P_SHORT = 20'd65536,
  parameter [`SSIC_WARM_W-1:0] P_LONG = 20'd196608
) (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_start,
  input wire i_long,
  input wire i_double,
  output wire o_busy,
  output wire o_done
);

  reg [`SSIC_WARM_W:0] cnt;
  reg [`SSIC_WARM_W:0] load;

  always @* begin
    load = i_long ? {1'b0, P_LONG} : {1'b0, P_SHORT};
    if (i_double) begin
      load = {load[`SSIC_WARM_W-1:0], 1'b0};
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= {(`SSIC_WARM_W+1){1'b0}};
    end else if (i_start) begin
      cnt <= load;
    end else if (cnt != {(`SSIC_WARM_W+1){1'b0}}) begin
      cnt <= cnt - {{`SSIC_WARM_W{1'b0}}, 1'b1};
    end
  end

  assign o_busy = (cnt != {(`SSIC_WARM_W+1){1'b0}});
  assign o_done = (cnt == {{`SSIC_WARM_W{1'b0}}, 1'b1});

endmodule // ssic_warmup

`default_nettype wire

/* ssic_wake_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// Wake pin source
// ********
module ssic_wake_src (
  input wire logic i_sys_clk,
  input wire logic i_level,
  input wire logic i_slow,
  output logic o_pin
);
  logic [2:0] dly = 3'b000;
  // Slow source lags one more cycle
  always @(posedge i_sys_clk) dly <= {dly[1:0], i_level};
  assign o_pin = i_slow ? dly[2] : dly[1];
endmodule // ssic_wake_src
`default_nettype wire

/* ssic_chk_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checker
// ********
module ssic_chk (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_wake_pin,
  input wire logic i_irq_master_enable,
  input wire logic o_osc_enable,
  input wire logic o_cpu_halt,
  input wire logic o_wdt_halt,
  input wire logic o_periph_halt,
  input wire logic o_hold_state,
  input wire logic o_divider_clear,
  input wire logic o_resume,
  input wire logic o_take_irq,
  input wire logic o_port_two_bit_zero
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  AST_STOP_HALT: assert property (!o_osc_enable |-> o_cpu_halt && o_periph_halt)
    else $error("halt low with oscillator off");
  AST_STOP_KEEP: assert property (!o_osc_enable |-> o_divider_clear && o_hold_state)
    else $error("hold or divider clear low in stop");
  AST_RESUME: assert property (o_resume |-> o_osc_enable ##1 (!o_resume && !o_cpu_halt))
    else $error("bad resume pulse");
  AST_ANSWER: assert property ($rose(i_avs_read || i_avs_write) |->
    o_avs_waitrequest ##1 o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer off time");
  AST_WAIT_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  AST_PIN: assert property ($rose(i_wake_pin) |-> ##[2:4] o_port_two_bit_zero)
    else $error("port bit not following pin");
  AST_IDLE: assert property (o_cpu_halt && !o_periph_halt |-> o_osc_enable && o_wdt_halt)
    else $error("idle state wrong");
  AST_IRQ: assert property (o_take_irq |-> i_irq_master_enable ##1 !o_take_irq)
    else $error("interrupt take wrong");
endmodule // ssic_chk
bind ssic_standby_ctrl ssic_chk i_ssic_chk (.i_sys_clk, .i_rstn, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .i_wake_pin, .i_irq_master_enable, .o_osc_enable, .o_cpu_halt,
  .o_wdt_halt, .o_periph_halt, .o_hold_state, .o_divider_clear, .o_resume, .o_take_irq,
  .o_port_two_bit_zero);
`default_nettype wire

/* ssic_standby_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// Bench
// ********
module ssic_standby_ctrl_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] adr = 10'h000;
  logic rd_r = 1'b0, wr_r = 1'b0, lvl = 1'b0, slow = 1'b0;
  logic div = 1'b0, mie = 1'b0, irq = 1'b0, ext0 = 1'b0;
  logic [31:0] wdat = 32'h0;
  wire logic pin, wq, osc, halt, wdt, per, dclr, res, tirq, p20, hold, irq5;
  wire logic [31:0] rdata;
  wire logic [1:0] resp;
  int fail_count = 0;
  int n_compared = 0;
  always #4 sys_clk = ~sys_clk;
  ssic_wake_src i_ssic_wake_src (.i_sys_clk(sys_clk), .i_level(lvl), .i_slow(slow), .o_pin(pin));
  ssic_standby_ctrl #(.P_WARM_SHORT(20'h8), .P_WARM_LONG(20'h18)) i_ssic_standby_ctrl (
    .i_sys_clk(sys_clk), .i_rstn(rstn), .i_avs_address(adr), .i_avs_read(rd_r),
    .i_avs_write(wr_r), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .o_avs_response(resp),
    .i_wake_pin(pin), .i_divider_input_select(div), .i_irq_master_enable(mie),
    .i_irq_pending(irq), .i_ext_irq_zero_input(ext0), .o_osc_enable(osc), .o_cpu_halt(halt),
    .o_wdt_halt(wdt), .o_periph_halt(per), .o_hold_state(hold), .o_divider_clear(dclr),
    .o_resume(res), .o_take_irq(tirq), .o_port_two_bit_zero(p20),
    .o_ext_irq_five_input(irq5));
  task automatic c(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic b(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    adr <= {a, 2'b00};
    wr_r <= w;
    rd_r <= ~w;
    wdat <= {24'h0, v};
    do begin
      @(posedge sys_clk);
      k++;
    end while (wq !== 1'b0 && k < 40);
    d = rdata;
    wr_r <= 1'b0;
    rd_r <= 1'b0;
  endtask
  // Counts cycles up to the resume pulse, noting any oscillator stop
  task automatic wr_wait(output int n, output logic lo);
    n = 0;
    lo = 1'b0;
    while (res !== 1'b1 && n < 300) begin
      if (osc !== 1'b1) lo = 1'b1;
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic t_regs;
    logic [31:0] d;
    b(1'b0, 8'h38, 8'h00, d);
    c(d, 32'h00);
    b(1'b0, 8'h39, 8'h00, d);
    c(d, 32'h80);
    b(1'b0, 8'h3c, 8'h00, d);
    c({d, resp}, {32'h0, 2'b11});
    b(1'b0, 8'h3a, 8'h00, d);
    c(d, 32'h0);
    b(1'b1, 8'h38, 8'h4c, d);
    cy(3);
    c({osc, halt}, 2'b10);
    b(1'b0, 8'h38, 8'h00, d);
    c(d, 32'h4c);
  endtask
  task automatic t_edge;
    logic [31:0] d;
    int n;
    logic lo;
    lvl <= 1'b1;
    cy(6);
    b(1'b1, 8'h38, 8'h90, d);
    cy(3);
    c({osc, dclr, halt, hold}, 4'b0111);
    lvl <= 1'b0;
    cy(6);
    c(osc, 1'b0);
    lvl <= 1'b1;
    wr_wait(n, lo);
    c(n >= 24 && n <= 30, 1'b1);
    b(1'b0, 8'h38, 8'h00, d);
    c(d[7], 1'b0);
  endtask
  task automatic t_level;
    logic [31:0] d;
    int n;
    logic lo;
    lvl <= 1'b0;
    cy(8);
    c(p20, 1'b0);
    div <= 1'b1;
    slow <= 1'b1;
    b(1'b1, 8'h38, 8'hd4, d);
    cy(3);
    c(osc, 1'b0);
    lvl <= 1'b1;
    wr_wait(n, lo);
    c(n >= 16 && n <= 23, 1'b1);
    div <= 1'b0;
    slow <= 1'b0;
    cy(6);
    b(1'b1, 8'h38, 8'hd4, d);
    wr_wait(n, lo);
    c({lo, res}, 2'b01);
  endtask
  task automatic t_idle;
    logic [31:0] d;
    int n;
    logic seen;
    mie <= 1'b1;
    b(1'b1, 8'h39, 8'h90, d);
    cy(2);
    c({halt, wdt, osc, per}, 4'b1110);
    irq <= 1'b1;
    n = 0;
    while (tirq !== 1'b1 && n < 10) begin
      @(posedge sys_clk);
      n++;
    end
    c(tirq, 1'b1);
    irq <= 1'b0;
    mie <= 1'b0;
    cy(2);
    c(halt, 1'b0);
    b(1'b1, 8'h39, 8'h90, d);
    cy(2);
    ext0 <= 1'b1;
    n = 0;
    seen = 1'b0;
    while (halt !== 1'b0 && n < 10) begin
      @(posedge sys_clk);
      if (tirq === 1'b1) seen = 1'b1;
      n++;
    end
    c({seen, halt}, 2'b00);
    ext0 <= 1'b0;
  endtask
  task automatic t_flag;
    logic [31:0] d;
    lvl <= 1'b0;
    cy(8);
    b(1'b0, 8'h3b, 8'h00, d);
    c({d[0], p20, irq5}, 3'b101);
    b(1'b1, 8'h3b, 8'h01, d);
    b(1'b0, 8'h3b, 8'h00, d);
    c({d[0], irq5}, 2'b00);
  endtask
  task automatic t_rst;
    logic [31:0] d;
    b(1'b1, 8'h38, 8'h90, d);
    cy(3);
    c(osc, 1'b0);
    rstn <= 1'b0;
    cy(2);
    c({osc, halt, wq}, 3'b101);
    rstn <= 1'b1;
    b(1'b0, 8'h38, 8'h00, d);
    c(d, 32'h00);
  endtask
  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cy(3);
    rstn <= 1'b1;
    t_regs;
    t_edge;
    t_level;
    t_idle;
    t_flag;
    t_rst;
    results;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    cy(5000);
    fail_count++;
    results;
  end
endmodule // ssic_standby_ctrl_tb
`default_nettype wire
